/* design/adcc_clk_div.sv */
// Converter clock source selection and prescaler, as an enable pulse.
// Assumes crystal_reference_clock is already synchronous to sys_clk.
`timescale 1ns/100ps
`default_nettype none
module adcc_clk_div
(
    input  wire logic       sys_clk,                 // Bus clock
    input  wire logic       reset_n,                 // Async reset, active low
    input  wire logic       clock_source_select,     // 1 bus clock, 0 crystal
    input  wire logic [2:0] clock_prescale,          // Divide code
    input  wire logic       crystal_reference_clock, // External reference level
    output logic            conv_tick                // One pulse per converter clock
);
    logic       xtal_q;
    logic [3:0] count_q;
    logic       src_tick;
    logic [3:0] limit;

    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
            xtal_q <= 1'b0;
        else
            xtal_q <= crystal_reference_clock;
    end

    assign src_tick = clock_source_select ? 1'b1 : (crystal_reference_clock & ~xtal_q);
    assign limit    = adcc_pkg::adcc_presc_limit(clock_prescale);

    // Counter wraps on limit; a code change mid-count is on software
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
            count_q <= 4'h0;
        else if (src_tick)
            count_q <= (count_q >= limit) ? 4'h0 : count_q + 4'h1;
    end

    assign conv_tick = src_tick && (count_q >= limit);

    // A smaller code can leave the count past the new limit for one tick
    AST_TICK_ON_LIMIT: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (src_tick && count_q <= adcc_pkg::adcc_presc_limit(clock_prescale))
        |-> conv_tick == (count_q == adcc_pkg::adcc_presc_limit(clock_prescale)))
        else $error("Converter tick off the prescaler limit");
    AST_BUS_DIV16: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (clock_source_select && clock_prescale[2] && conv_tick) |=> !conv_tick [*8])
        else $error("Divide by 16 ticks too soon");
    AST_BUS_SOURCE: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (clock_source_select && clock_prescale == 3'b000) |-> conv_tick)
        else $error("Bus source divide by 1 missed a tick");
endmodule : adcc_clk_div
`default_nettype wire

/* design/adcc_pkg.sv */
// Constants, types and helpers shared by the converter control block.
// Assumes one bus clock, sys_clk, and an active-low asynchronous reset.
// How it works
// - A 5-bit channel_select field chooses one of 15 external analog inputs.
// - Codes 0 to 14 route analog_input 0 to 14; 0-7 port B, 8-14 port D.
// - Codes 0x0F to 0x1A, 0x1C unused and 0x1B reserved; their result is undefined.
// - Code 0x1D selects high_reference, code 0x1E selects low_reference.
// - All five channel_select bits set switches the converter off.
// - Reset sets every channel_select bit, so the converter starts powered off.
// - One 8-bit conversion_result register, overwritten at every conversion end.
// - clock_prescale divides by 1, 2, 4, 8, or 16 when its top bit is set.
// - clock_source_select one picks bus clock, zero picks crystal_reference_clock.
// - Reset clears clock_source_select, selecting crystal_reference_clock.
// - Writing status and control starts a conversion lasting 16 to 17 converter clocks.
// - conversion_complete sets at conversion end; cleared by control write or result read.
// - With completion_irq_enable, conversion end interrupts; result read or control write clears.
// - continuous_conversion repeats conversions back to back; otherwise one per start.
package adcc_pkg;
    // Byte addresses on the register bus
    localparam logic [4:0] ADCC_OFS_STATUS_CONTROL = 5'h00;
    localparam logic [4:0] ADCC_OFS_RESULT         = 5'h04;
    localparam logic [4:0] ADCC_OFS_CLOCK_CONFIG   = 5'h08;
    localparam logic [4:0] ADCC_OFS_IRQ_STATUS     = 5'h0C;
    localparam logic [4:0] ADCC_OFS_IRQ_MASK       = 5'h10;

    // Field positions
    localparam int ADCC_SC_CONVERSION_COMPLETE_BIT    = 7;
    localparam int ADCC_SC_COMPLETION_IRQ_ENABLE_BIT    = 6;
    localparam int ADCC_SC_CONT_BIT    = 5;
    localparam int ADCC_CC_SOURCE_BIT  = 4;
    localparam int ADCC_CC_PRESC_LSB   = 5;
    localparam int ADCC_IRQ_DONE_BIT   = 0;

    // Values after reset
    localparam logic [7:0] ADCC_SC_RESET       = 8'h1F;
    localparam logic [7:0] ADCC_CC_RESET       = 8'h00;
    localparam logic [7:0] ADCC_IRQ_MASK_RESET = 8'h01;

    // Channel codes
    localparam logic [4:0] ADCC_CH_LAST_EXT  = 5'h0E;
    localparam logic [4:0] ADCC_CH_HIGH_REF  = 5'h1D;
    localparam logic [4:0] ADCC_CH_LOW_REF   = 5'h1E;
    localparam logic [4:0] ADCC_CH_POWER_OFF = 5'h1F;

    // Conversion timing in converter clocks
    localparam logic [3:0] ADCC_LAST_SAMPLE_STEP = 4'h7;
    localparam logic [3:0] ADCC_LAST_STEP        = 4'hF;
    // Start one step early: the first tick only aligns to the converter clock
    localparam logic [3:0] ADCC_START_STEP       = 4'hF;
    localparam logic [7:0] ADCC_SAR_FIRST_TRIAL  = 8'h80;

    typedef enum logic [1:0]
    {
        ADCC_IDLE   = 2'b00,
        ADCC_SAMPLE = 2'b01,
        ADCC_APPROX = 2'b11
    } adcc_conv_state_type;

    // Terminal count of the prescaler for a clock_prescale code
    function automatic logic [3:0] adcc_presc_limit(input logic [2:0] code);
        logic [3:0] lim;
        lim = 4'hF;
        unique case (code[1:0])
            2'b00: lim = 4'h0;
            2'b01: lim = 4'h1;
            2'b10: lim = 4'h3;
            2'b11: lim = 4'h7;
        endcase
        if (code[2])
            lim = 4'hF;
        return lim;
    endfunction : adcc_presc_limit

    // One-hot external input enables for a channel code
    function automatic logic [14:0] adcc_ext_select(input logic [4:0] ch);
        logic [14:0] sel;
        sel = 15'h0000;
        if (ch <= ADCC_CH_LAST_EXT)
            sel[ch[3:0]] = 1'b1;
        return sel;
    endfunction : adcc_ext_select
endpackage : adcc_pkg

/* design/adcc_sar.sv */
// Successive approximation sequencer: align tick, 8 sample clocks, 8 bit decisions.
// Assumes comparator_above is valid one converter clock after dac_code moves.
`timescale 1ns/100ps
`default_nettype none
module adcc_sar
(
    input  wire logic       sys_clk,          // Bus clock
    input  wire logic       reset_n,          // Async reset, active low
    input  wire logic       start,            // Begin or restart a conversion
    input  wire logic       stop,             // Abandon any conversion
    input  wire logic       conv_tick,        // Converter clock enable
    input  wire logic       comparator_above, // Input above dac_code
    output logic            busy,             // Conversion running
    output logic            done,             // One-cycle end pulse
    output logic [7:0]      dac_code          // Trial code, final value at done
);
    adcc_pkg::adcc_conv_state_type state_q;
    logic [3:0] step_q;
    logic [2:0] bit_idx;

    assign busy    = (state_q != adcc_pkg::ADCC_IDLE);
    assign bit_idx = ~step_q[2:0];

    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state_q  <= adcc_pkg::ADCC_IDLE;
            step_q   <= 4'h0;
            dac_code <= 8'h00;
        end
        else if (stop)
            state_q <= adcc_pkg::ADCC_IDLE;
        else if (start)
        begin
            // Extra aligning tick keeps the length at 16 to 17 converter clocks
            state_q <= adcc_pkg::ADCC_SAMPLE;
            step_q  <= adcc_pkg::ADCC_START_STEP;
        end
        else if (conv_tick)
        begin
            unique case (state_q)
                adcc_pkg::ADCC_IDLE: ;
                adcc_pkg::ADCC_SAMPLE:
                begin
                    step_q <= step_q + 4'h1;
                    if (step_q == adcc_pkg::ADCC_LAST_SAMPLE_STEP)
                    begin
                        state_q  <= adcc_pkg::ADCC_APPROX;
                        dac_code <= adcc_pkg::ADCC_SAR_FIRST_TRIAL;
                    end
                end
                adcc_pkg::ADCC_APPROX:
                begin
                    step_q <= step_q + 4'h1;
                    dac_code[bit_idx] <= comparator_above;
                    if (bit_idx != 3'd0)
                        dac_code[bit_idx - 3'd1] <= 1'b1;
                    if (step_q == adcc_pkg::ADCC_LAST_STEP)
                        state_q <= adcc_pkg::ADCC_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
            done <= 1'b0;
        else
            done <= !stop && !start && conv_tick && state_q == adcc_pkg::ADCC_APPROX
                    && step_q == adcc_pkg::ADCC_LAST_STEP;
    end

    AST_DONE_AT_STEP16: assert property (@(posedge sys_clk) disable iff (!reset_n)
        done |-> $past(step_q) == adcc_pkg::ADCC_LAST_STEP && !busy)
        else $error("Conversion ended before sixteen converter clocks");
    AST_START_SAMPLES: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (start && !stop) |=> state_q == adcc_pkg::ADCC_SAMPLE
                             && step_q == adcc_pkg::ADCC_START_STEP)
        else $error("Start did not begin sampling");
endmodule : adcc_sar
`default_nettype wire

/* design/adcc_top.sv */
// Converter control: channel mux, power, clocking, result and interrupt.
// Assumes an Avalon-MM master on sys_clk; low byte of each word is used.
`timescale 1ns/100ps
`default_nettype none
module adcc_top
(
    input  wire logic        sys_clk,                 // Bus clock, 100 MHz
    input  wire logic        reset_n,                 // Async reset, active low
    input  wire logic [4:0]  address,                 // Avalon byte address
    input  wire logic        read,                    // Avalon read
    input  wire logic        write,                   // Avalon write
    input  wire logic [3:0]  byteenable,              // Avalon byte enables
    input  wire logic [31:0] writedata,               // Avalon write data
    output logic [31:0]      readdata,                // Avalon read data
    output logic             waitrequest,             // Avalon wait
    output logic             irq,                     // Level interrupt
    input  wire logic        crystal_reference_clock, // External reference clock
    input  wire logic        comparator_above,        // Analog compare result
    output logic [7:0]       dac_code,                // Trial code to the DAC
    output logic [7:0]       analog_input_sel_b,      // Inputs 0-7 enables
    output logic [6:0]       analog_input_sel_d,      // Inputs 8-14 enables
    output logic             high_reference_sel,      // Internal high node
    output logic             low_reference_sel,       // Internal low node
    output logic             converter_power_on       // Analog power enable
);
    logic       ack_q;
    logic       wr_byte;
    logic       wr_sc;
    logic       wr_cc;
    logic       wr_irq_status;
    logic       wr_irq_mask;
    logic       rd_result;
    logic [4:0] channel_select_q;
    logic       continuous_conversion_q;
    logic       completion_irq_enable_q;
    logic       conversion_complete_q;
    logic       clock_source_select_q;
    logic [2:0] clock_prescale_q;
    logic [7:0] conversion_result_q;
    logic [7:0] irq_status_q;
    logic [7:0] irq_mask_q;
    logic [7:0] rd_byte;
    logic       new_off;
    logic       conv_tick;
    logic       conv_busy;
    logic       conv_done;
    logic       conv_start;
    logic       conv_stop;
    logic [7:0] sar_code;

    // Bus slave: one wait state, every access answered at the second edge
    assign waitrequest = (read || write) && !ack_q;

    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
            ack_q <= 1'b0;
        else
            ack_q <= (read || write) && !ack_q;
    end

    assign wr_byte       = write && ack_q && byteenable[0];
    assign wr_sc         = wr_byte && address == adcc_pkg::ADCC_OFS_STATUS_CONTROL;
    assign wr_cc         = wr_byte && address == adcc_pkg::ADCC_OFS_CLOCK_CONFIG;
    assign wr_irq_status = wr_byte && address == adcc_pkg::ADCC_OFS_IRQ_STATUS;
    assign wr_irq_mask   = wr_byte && address == adcc_pkg::ADCC_OFS_IRQ_MASK;
    assign rd_result     = read && ack_q && address == adcc_pkg::ADCC_OFS_RESULT;

    always_comb
    begin
        rd_byte = 8'h00;
        unique case (address)
            adcc_pkg::ADCC_OFS_STATUS_CONTROL:
                rd_byte = {conversion_complete_q, completion_irq_enable_q,
                           continuous_conversion_q, channel_select_q};
            adcc_pkg::ADCC_OFS_RESULT:
                rd_byte = conversion_result_q;
            adcc_pkg::ADCC_OFS_CLOCK_CONFIG:
                rd_byte = {clock_prescale_q, clock_source_select_q, 4'h0};
            adcc_pkg::ADCC_OFS_IRQ_STATUS:
                rd_byte = irq_status_q;
            adcc_pkg::ADCC_OFS_IRQ_MASK:
                rd_byte = irq_mask_q;
            default:
                rd_byte = 8'h00;
        endcase
    end

    // Data captured in the wait cycle so it stands at the answering edge
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
            readdata <= 32'h0000_0000;
        else if (read && !ack_q)
            readdata <= {24'h00_0000, rd_byte};
    end

    // Status and control fields
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            channel_select_q        <= adcc_pkg::ADCC_SC_RESET[4:0];
            continuous_conversion_q <= adcc_pkg::ADCC_SC_RESET[adcc_pkg::ADCC_SC_CONT_BIT];
            completion_irq_enable_q <= adcc_pkg::ADCC_SC_RESET[adcc_pkg::ADCC_SC_COMPLETION_IRQ_ENABLE_BIT];
        end
        else if (wr_sc)
        begin
            channel_select_q        <= writedata[4:0];
            continuous_conversion_q <= writedata[adcc_pkg::ADCC_SC_CONT_BIT];
            completion_irq_enable_q <= writedata[adcc_pkg::ADCC_SC_COMPLETION_IRQ_ENABLE_BIT];
        end
    end

    // Clock configuration; changes mid-conversion corrupt only that result
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            clock_source_select_q <= adcc_pkg::ADCC_CC_RESET[adcc_pkg::ADCC_CC_SOURCE_BIT];
            clock_prescale_q      <= adcc_pkg::ADCC_CC_RESET[7:5];
        end
        else if (wr_cc)
        begin
            clock_source_select_q <= writedata[adcc_pkg::ADCC_CC_SOURCE_BIT];
            clock_prescale_q      <= writedata[adcc_pkg::ADCC_CC_PRESC_LSB +: 3];
        end
    end

    // Analog side enables; unused and reserved codes connect nothing
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            analog_input_sel_b <= 8'h00;
            analog_input_sel_d <= 7'h00;
            high_reference_sel <= 1'b0;
            low_reference_sel  <= 1'b0;
            converter_power_on <= 1'b0;
        end
        else
        begin
            {analog_input_sel_d, analog_input_sel_b} <= adcc_pkg::adcc_ext_select(channel_select_q);
            high_reference_sel <= channel_select_q == adcc_pkg::ADCC_CH_HIGH_REF;
            low_reference_sel  <= channel_select_q == adcc_pkg::ADCC_CH_LOW_REF;
            converter_power_on <= channel_select_q != adcc_pkg::ADCC_CH_POWER_OFF;
        end
    end

    // Conversion sequencing
    assign new_off    = writedata[4:0] == adcc_pkg::ADCC_CH_POWER_OFF;
    assign conv_stop  = wr_sc && new_off;
    assign conv_start = (wr_sc && !new_off)
                        || (conv_done && continuous_conversion_q && !wr_sc
                            && channel_select_q != adcc_pkg::ADCC_CH_POWER_OFF);

    adcc_clk_div u_clk_div
    (
        .sys_clk                 (sys_clk),
        .reset_n                 (reset_n),
        .clock_source_select     (clock_source_select_q),
        .clock_prescale          (clock_prescale_q),
        .crystal_reference_clock (crystal_reference_clock),
        .conv_tick               (conv_tick)
    );

    adcc_sar u_sar
    (
        .sys_clk          (sys_clk),
        .reset_n          (reset_n),
        .start            (conv_start),
        .stop             (conv_stop),
        .conv_tick        (conv_tick),
        .comparator_above (comparator_above),
        .busy             (conv_busy),
        .done             (conv_done),
        .dac_code         (sar_code)
    );

    assign dac_code = sar_code;

    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
            conversion_result_q <= 8'h00;
        else if (conv_done)
            conversion_result_q <= sar_code;
    end

    // Completion flag: a finishing conversion beats a same-cycle clear
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
            conversion_complete_q <= 1'b0;
        else if (conv_done)
            conversion_complete_q <= 1'b1;
        else if (wr_sc || rd_result)
            conversion_complete_q <= 1'b0;
    end

    // Sticky interrupt status, write one to clear; also cleared like the flag
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
            irq_status_q <= 8'h00;
        else if (conv_done)
            irq_status_q[adcc_pkg::ADCC_IRQ_DONE_BIT] <= 1'b1;
        else if (wr_sc || rd_result)
            irq_status_q[adcc_pkg::ADCC_IRQ_DONE_BIT] <= 1'b0;
        else if (wr_irq_status)
            irq_status_q <= irq_status_q & ~writedata[7:0];
    end

    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
            irq_mask_q <= adcc_pkg::ADCC_IRQ_MASK_RESET;
        else if (wr_irq_mask)
            irq_mask_q <= writedata[7:0];
    end

    assign irq = completion_irq_enable_q && |(irq_status_q & irq_mask_q);

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!reset_n);

    sequence seq_conv_end;
        conv_done && !wr_sc && !rd_result;
    endsequence
    sequence seq_flag_clear;
        (wr_sc || rd_result) && !conv_done;
    endsequence

    AST_RESET_OFF: assert property ($rose(reset_n) |-> channel_select_q == 5'h1F)
        else $error("Channel select not all ones after reset");
    AST_POWER_OFF: assert property (
        channel_select_q == adcc_pkg::ADCC_CH_POWER_OFF |=> !converter_power_on)
        else $error("Converter powered in power-off code");
    AST_EXT_ROUTE: assert property (
        (channel_select_q <= adcc_pkg::ADCC_CH_LAST_EXT && $stable(channel_select_q))
        |=> {analog_input_sel_d, analog_input_sel_b} == (15'h0001 << $past(channel_select_q)))
        else $error("External input route wrong");
    AST_UNUSED_NONE: assert property (
        (channel_select_q > adcc_pkg::ADCC_CH_LAST_EXT
         && channel_select_q < adcc_pkg::ADCC_CH_HIGH_REF)
        |=> {analog_input_sel_d, analog_input_sel_b, high_reference_sel, low_reference_sel} == 17'h0_0000)
        else $error("Unused code connected an input");
    AST_REF_NODES: assert property (
        channel_select_q == adcc_pkg::ADCC_CH_HIGH_REF |=> high_reference_sel && !low_reference_sel)
        else $error("High reference not selected");
    AST_NO_CONV_OFF: assert property (
        channel_select_q == adcc_pkg::ADCC_CH_POWER_OFF && !wr_sc
        |=> !conv_busy && $stable(conversion_result_q))
        else $error("Conversion ran in power-off code");
    AST_FLAG_SET: assert property (seq_conv_end |=> conversion_complete_q
        && conversion_result_q == $past(sar_code))
        else $error("Conversion end did not set flag and result");
    AST_FLAG_CLEAR: assert property (seq_flag_clear |=> !conversion_complete_q)
        else $error("Flag not cleared by write or result read");
    AST_IRQ_RAISE: assert property (
        seq_conv_end ##0 completion_irq_enable_q && irq_mask_q[0] && !wr_irq_mask |=> irq)
        else $error("Interrupt not raised at conversion end");
    AST_CONT_REPEAT: assert property (
        conv_done && continuous_conversion_q && !wr_sc
        && channel_select_q != adcc_pkg::ADCC_CH_POWER_OFF |=> conv_busy)
        else $error("Continuous mode did not restart");
    AST_SINGLE_STOP: assert property (conv_done && !continuous_conversion_q && !wr_sc
        |=> !conv_busy)
        else $error("Single mode restarted");
    AST_WAIT_ONE: assert property ((read || write) && !ack_q |=> !waitrequest)
        else $error("Bus answer not in one wait state");
endmodule : adcc_top
`default_nettype wire

/* test/tb.sv */
// Self-checking bench for the converter control block: registers, mux, timing, irq.
// Assumes adcc_top with its one-wait-state Avalon slave and adcc_pkg offsets.
`timescale 1ns/100ps
`default_nettype none
module tb;
    logic        sys_clk          = 1'b0;
    logic        reset_n          = 1'b0;
    logic [4:0]  address          = 5'h00;
    logic        read             = 1'b0;
    logic        write            = 1'b0;
    logic [31:0] writedata        = 32'h0000_0000;
    logic        comparator_above = 1'b1;
    logic [1:0]  xph              = 2'h0;
    logic [31:0] readdata, rd;
    logic        waitrequest, irq, hi_sel, lo_sel, pwr_on;
    logic [7:0]  dac_code, sel_b;
    logic [6:0]  sel_d;
    int          failures         = 0;
    int          total_checks     = 0;

    always #5 sys_clk = ~sys_clk;
    // Crystal at a quarter of the bus rate, kept synchronous as the block expects
    always @(posedge sys_clk) xph <= xph + 2'h1;

    adcc_top DUT (.sys_clk(sys_clk), .reset_n(reset_n), .address(address), .read(read),
        .write(write), .byteenable(4'h1), .writedata(writedata), .readdata(readdata),
        .waitrequest(waitrequest), .irq(irq), .crystal_reference_clock(xph[1]),
        .comparator_above(comparator_above), .dac_code(dac_code),
        .analog_input_sel_b(sel_b), .analog_input_sel_d(sel_d),
        .high_reference_sel(hi_sel), .low_reference_sel(lo_sel),
        .converter_power_on(pwr_on));

    task automatic stop_test;
        $display("checks %0d, mismatches %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : stop_test

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            failures++;
            $display("unexpected at %0t: got %h, want %h", $time, got, exp);
        end
    endtask : chk

    // Request held until waitrequest is sampled low at a rising edge
    task automatic bus(input logic wr, input logic [4:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        address   <= a;
        writedata <= {24'h00_0000, d};
        write     <= wr;
        read      <= ~wr;
        @(posedge sys_clk);
        while (waitrequest)
            @(posedge sys_clk);
        rd = readdata;
        write <= 1'b0;
        read  <= 1'b0;
    endtask : bus

    task automatic reset_values;
        bus(1'b0, adcc_pkg::ADCC_OFS_STATUS_CONTROL, 8'h00);
        chk(rd, 32'h0000_001F);
        bus(1'b0, adcc_pkg::ADCC_OFS_CLOCK_CONFIG, 8'h00);
        chk(rd, 32'h0000_0000);
        chk({31'h0, pwr_on}, 32'h0000_0000);
    endtask : reset_values

    task automatic mux_codes;
        for (int c = 0; c < 32; c++)
        begin
            bus(1'b1, adcc_pkg::ADCC_OFS_STATUS_CONTROL, 8'(c));
            repeat (2) @(posedge sys_clk);
            chk({17'h0, sel_d, sel_b}, (c < 15) ? 32'h1 << c : 32'h0);
            chk({29'h0, hi_sel, lo_sel, pwr_on}, {29'h0, c == 29, c == 30, c != 31});
        end
    endtask : mux_codes

    // One conversion with irq enabled; d is the converter clock length in bus cycles
    task automatic conv(input logic [7:0] cc, input int d, input logic cmp);
        int n;
        n = 0;
        comparator_above <= cmp;
        bus(1'b1, adcc_pkg::ADCC_OFS_CLOCK_CONFIG, cc);
        bus(1'b1, adcc_pkg::ADCC_OFS_STATUS_CONTROL, 8'h45);
        while (irq !== 1'b1 && n < 400)
        begin
            @(posedge sys_clk);
            n++;
        end
        chk(32'((n >= 16 * d - 1) && (n <= 17 * d + 4)), 32'h1);
        bus(1'b0, adcc_pkg::ADCC_OFS_STATUS_CONTROL, 8'h00);
        chk(rd, 32'h0000_00C5);
        bus(1'b0, adcc_pkg::ADCC_OFS_RESULT, 8'h00);
        chk(rd, {24'h0, {8{cmp}}});
        chk({24'h0, dac_code}, {24'h0, {8{cmp}}});
        @(posedge sys_clk);
        chk({31'h0, irq}, 32'h0);
    endtask : conv

    task automatic power_off_hold;
        comparator_above <= 1'b0;
        bus(1'b1, adcc_pkg::ADCC_OFS_STATUS_CONTROL, 8'h5F);
        // Long enough for a wrongly started conversion to finish
        repeat (100) @(posedge sys_clk);
        bus(1'b0, adcc_pkg::ADCC_OFS_RESULT, 8'h00);
        chk(rd, 32'h0000_00FF);
        chk({31'h0, irq}, 32'h0);
    endtask : power_off_hold

    task automatic mask_and_clear;
        bus(1'b1, adcc_pkg::ADCC_OFS_IRQ_MASK, 8'h00);
        // First result after power off is the settling one and is never trusted
        bus(1'b1, adcc_pkg::ADCC_OFS_STATUS_CONTROL, 8'h45);
        repeat (100) @(posedge sys_clk);
        chk({31'h0, irq}, 32'h0);
        bus(1'b0, adcc_pkg::ADCC_OFS_IRQ_STATUS, 8'h00);
        chk(rd, 32'h0000_0001);
        bus(1'b1, adcc_pkg::ADCC_OFS_IRQ_MASK, 8'h01);
        @(posedge sys_clk);
        chk({31'h0, irq}, 32'h1);
        bus(1'b1, adcc_pkg::ADCC_OFS_IRQ_STATUS, 8'h01);
        @(posedge sys_clk);
        chk({31'h0, irq}, 32'h0);
        bus(1'b0, 5'h14, 8'h00);
        chk(rd, 32'h0000_0000);
    endtask : mask_and_clear

    // Flag comes back without a new start only if conversions repeat
    task automatic continuous_run;
        comparator_above <= 1'b1;
        bus(1'b1, adcc_pkg::ADCC_OFS_STATUS_CONTROL, 8'h25);
        repeat (100) @(posedge sys_clk);
        bus(1'b0, adcc_pkg::ADCC_OFS_RESULT, 8'h00);
        chk(rd, 32'h0000_00FF);
        repeat (100) @(posedge sys_clk);
        bus(1'b0, adcc_pkg::ADCC_OFS_STATUS_CONTROL, 8'h00);
        chk(rd, 32'h0000_00A5);
    endtask : continuous_run

    initial
    begin
        repeat (20000) @(posedge sys_clk);
        failures++;
        stop_test();
    end

    initial
    begin
        repeat (20) @(posedge sys_clk);
        reset_n <= 1'b1;
        reset_values();
        mux_codes();
        conv(8'h10, 1, 1'b1);
        conv(8'h30, 2, 1'b0);
        conv(8'h50, 4, 1'b1);
        conv(8'h70, 8, 1'b0);
        conv(8'hF0, 16, 1'b1);
        conv(8'h00, 4, 1'b1);
        power_off_hold();
        mask_and_clear();
        continuous_run();
        stop_test();
    end
endmodule : tb
`default_nettype wire
